// File: shared/e1ssm_pkg.sv
/*
 Constants of the E1 sync status monitor: register offsets, bit positions,
 reset values and criterion counts. Assumes a 20 MHz system clock.
*/
package e1ssm_pkg;
    localparam logic [7:0] RECV_INFO_ADDR = 8'h08;
    localparam logic [7:0] SYNC_STAT_ADDR = 8'h1e;
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h10;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h11;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h12;

    localparam int TX_FULL_BIT = 7;
    localparam int TX_EMPTY_BIT = 6;
    localparam int SPARE_BIT = 5;
    localparam int RX_FULL_BIT = 4;
    localparam int RX_EMPTY_BIT = 3;
    localparam int CRC_RESYNC_BIT = 2;
    localparam int ALIGN_RESYNC_BIT = 1;
    localparam int SIG_RESYNC_BIT = 0;
    localparam int CRC_EN_BIT = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [5:0] COUNT_RESET = 6'h00;

    localparam logic [9:0] CRC_WINDOW = 10'd1000;
    localparam logic [9:0] CRC_ERR_LIMIT = 10'd915;
    localparam int ALIGN_ERR_RUN = 3;
    localparam int SIG_ERR_RUN = 2;

    localparam int SEARCH_MS = 8;
    localparam int CLK_KHZ = 20000;
    localparam int SEARCH_CYCLES = SEARCH_MS * CLK_KHZ;
    localparam int TIMER_W = 18;
endpackage

// File: shared/e1ssm_word_if.sv
/*
 Word stream with error mark between the monitor and its run counters.
 Assumes all signals are on the monitor clock.
*/
`timescale 1ns/1ps
interface e1ssm_word_if;
    logic word;
    logic err;
    logic met;
    modport src (output word, output err, input met);
    modport mon (input word, input err, output met);
endinterface

// File: hdl/e1ssm_err_run.sv
/*
 Counter of consecutive errored words; pulses met when the run reaches RUN.
 Assumes word and err are same-clock one-cycle strobes.
*/
`timescale 1ns/1ps
module e1ssm_err_run #(
    parameter int RUN = 3
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    e1ssm_word_if.mon w
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic met_q;
    logic met_d;
    wire last_w = (cnt_q == 3'(RUN - 1));

    // Run grows on errors, restarts on a good word or when met
    assign met_d = w.word && w.err && last_w;
    assign cnt_d = !w.word ? cnt_q : (!w.err || last_w) ? 3'h0 : cnt_q + 3'h1;
    assign w.met = met_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= 3'h0;
            met_q <= 1'b0;
        end else if (clk_en_i) begin
            cnt_q <= cnt_d;
            met_q <= met_d;
        end
    end

    a_run_met_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && w.word && w.err && last_w |=> met_q)
        else $error("run criterion not flagged");
    a_good_word_resets: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && w.word && !w.err |=> cnt_q == 3'h0 && !met_q)
        else $error("good word did not restart run");
endmodule

// File: hdl/e1ssm_status_monitor.sv
/*
 Status monitor of one E1 framer: elastic store events, resync criteria,
 search flags and the CRC4 search counter, with registers and interrupt.
 Assumes framer inputs and the register port are on clk_i.
*/
`timescale 1ns/1ps
module e1ssm_status_monitor #(
    parameter int SEARCH_CYCLES = e1ssm_pkg::SEARCH_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    input wire logic tx_store_full_i,
    input wire logic tx_store_empty_i,
    input wire logic rx_store_full_i,
    input wire logic rx_store_empty_i,
    input wire logic crc_word_i,
    input wire logic crc_word_err_i,
    input wire logic align_word_i,
    input wire logic align_word_err_i,
    input wire logic sig_word_i,
    input wire logic sig_word_err_i,
    input wire logic align_search_active_i,
    input wire logic signaling_search_active_i,
    input wire logic crc_search_active_i,
    input wire logic crc_sync_achieved_i,
    output logic crc_mode_en_o
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [5:0] count_q;
    logic [5:0] count_d;
    logic [e1ssm_pkg::TIMER_W-1:0] timer_q;
    logic [e1ssm_pkg::TIMER_W-1:0] timer_d;
    logic [9:0] wcnt_q;
    logic [9:0] wcnt_d;
    logic [9:0] ecnt_q;
    logic [9:0] ecnt_d;
    logic crc_met_q;
    logic crc_met_d;
    logic [7:0] rdata_d;

    e1ssm_word_if align_if ();
    e1ssm_word_if sig_if ();

    // Alignment word run counter
    assign align_if.word = align_word_i;
    assign align_if.err = align_word_err_i;
    e1ssm_err_run #(.RUN(e1ssm_pkg::ALIGN_ERR_RUN)) u_align_run (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .w(align_if.mon)
    );

    // Signaling multiframe word run counter
    assign sig_if.word = sig_word_i;
    assign sig_if.err = sig_word_err_i;
    e1ssm_err_run #(.RUN(e1ssm_pkg::SIG_ERR_RUN)) u_sig_run (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .w(sig_if.mon)
    );

    // Register decode
    wire wr_ctrl_w = wr_i && (addr_i == e1ssm_pkg::CTRL_ONE_ADDR);
    wire wr_stat_w = wr_i && (addr_i == e1ssm_pkg::IRQ_STAT_ADDR);
    wire wr_mask_w = wr_i && (addr_i == e1ssm_pkg::IRQ_MASK_ADDR);
    wire crc_en_w = ctrl_q[e1ssm_pkg::CRC_EN_BIT];

    // CRC4 code word window: 1000 words, criterion at the 915th error
    wire crc_err_w = crc_word_i && crc_word_err_i;
    wire win_end_w = crc_word_i && (wcnt_q == e1ssm_pkg::CRC_WINDOW - 10'd1);
    wire [9:0] ecnt_next_w = crc_err_w ? ecnt_q + 10'd1 : ecnt_q;
    assign crc_met_d = crc_err_w && (ecnt_next_w == e1ssm_pkg::CRC_ERR_LIMIT);
    assign wcnt_d = !crc_word_i ? wcnt_q : win_end_w ? 10'd0 : wcnt_q + 10'd1;
    assign ecnt_d = win_end_w ? 10'd0 : ecnt_next_w;

    // Event vector in receive_information layout
    logic [7:0] event_w;
    always_comb begin
        event_w = 8'h00;
        event_w[e1ssm_pkg::TX_FULL_BIT] = tx_store_full_i;
        event_w[e1ssm_pkg::TX_EMPTY_BIT] = tx_store_empty_i;
        event_w[e1ssm_pkg::RX_FULL_BIT] = rx_store_full_i;
        event_w[e1ssm_pkg::RX_EMPTY_BIT] = rx_store_empty_i;
        event_w[e1ssm_pkg::CRC_RESYNC_BIT] = crc_met_q;
        event_w[e1ssm_pkg::ALIGN_RESYNC_BIT] = align_if.met;
        event_w[e1ssm_pkg::SIG_RESYNC_BIT] = sig_if.met;
    end

    // Sticky flags: write one clears, a new event wins; spare bit held zero
    wire [7:0] clr_w = wr_stat_w ? wdata_i : 8'h00;
    wire [7:0] used_w = ~(8'h01 << e1ssm_pkg::SPARE_BIT);
    assign stat_d = ((stat_q & ~clr_w) | event_w) & used_w;
    assign ctrl_d = wr_ctrl_w ? wdata_i : ctrl_q;
    assign mask_d = wr_mask_w ? (wdata_i & used_w) : mask_q;
    assign irq_o = |(stat_q & mask_q);
    assign crc_mode_en_o = crc_en_w;

    // 8 ms CRC4 multiframe search timer
    wire searching_w = crc_en_w && crc_search_active_i;
    wire timeout_w = searching_w && (timer_q == e1ssm_pkg::TIMER_W'(SEARCH_CYCLES - 1));
    assign timer_d = (!searching_w || timeout_w) ? '0 : timer_q + 1'b1;

    // CRC4 search counter
    wire mode_off_w = wr_ctrl_w && !wdata_i[e1ssm_pkg::CRC_EN_BIT];
    wire count_clr_w = crc_sync_achieved_i || mode_off_w || !crc_en_w;
    assign count_d = count_clr_w ? 6'h00 : timeout_w ? count_q + 6'h01 : count_q;

    // Read mux
    wire [7:0] sync_stat_w = {count_q[5:2], count_q[0],
        align_search_active_i, signaling_search_active_i, crc_search_active_i};
    always_comb begin
        case (addr_i)
            e1ssm_pkg::RECV_INFO_ADDR: rdata_d = stat_q;
            e1ssm_pkg::SYNC_STAT_ADDR: rdata_d = sync_stat_w;
            e1ssm_pkg::CTRL_ONE_ADDR: rdata_d = ctrl_q;
            e1ssm_pkg::IRQ_STAT_ADDR: rdata_d = stat_q;
            e1ssm_pkg::IRQ_MASK_ADDR: rdata_d = mask_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Control and mask registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= e1ssm_pkg::CTRL_RESET;
        end else if (clk_en_i) begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mask_q <= e1ssm_pkg::MASK_RESET;
        end else if (clk_en_i) begin
            mask_q <= mask_d;
        end
    end

    // Sticky status flags
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stat_q <= e1ssm_pkg::STAT_RESET;
        end else if (clk_en_i) begin
            stat_q <= stat_d;
        end
    end

    // Search counter and timer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_q <= e1ssm_pkg::COUNT_RESET;
        end else if (clk_en_i) begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            timer_q <= '0;
        end else if (clk_en_i) begin
            timer_q <= timer_d;
        end
    end

    // CRC4 code word window
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wcnt_q <= 10'd0;
            ecnt_q <= 10'd0;
        end else if (clk_en_i) begin
            wcnt_q <= wcnt_d;
            ecnt_q <= ecnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            crc_met_q <= 1'b0;
        end else if (clk_en_i) begin
            crc_met_q <= crc_met_d;
        end
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            rdata_o <= rd_i ? rdata_d : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_tx_full_set: assert property (clk_en_i && tx_store_full_i |=> stat_q[7])
        else $error("tx full flag not set");
    a_tx_empty_set: assert property (clk_en_i && tx_store_empty_i |=> stat_q[6])
        else $error("tx empty flag not set");
    a_spare_reads_zero: assert property (
        clk_en_i && rd_i && addr_i == e1ssm_pkg::RECV_INFO_ADDR |=> !rdata_o[5])
        else $error("spare bit read as one");
    a_rx_full_set: assert property (clk_en_i && rx_store_full_i |=> stat_q[4])
        else $error("rx full flag not set");
    a_rx_empty_set: assert property (clk_en_i && rx_store_empty_i |=> stat_q[3])
        else $error("rx empty flag not set");
    a_crc_limit_flag: assert property (
        clk_en_i && crc_err_w && ecnt_q == 10'd914 ##1 clk_en_i |=> stat_q[2])
        else $error("crc criterion not flagged");
    a_align_flag_set: assert property (clk_en_i && align_if.met |=> stat_q[1])
        else $error("alignment resync not flagged");
    a_sig_flag_set: assert property (clk_en_i && sig_if.met |=> stat_q[0])
        else $error("signaling resync not flagged");
    a_count_readback: assert property (
        clk_en_i && rd_i && addr_i == e1ssm_pkg::SYNC_STAT_ADDR
        |=> rdata_o[7:3] == {$past(count_q[5:2]), $past(count_q[0])})
        else $error("counter readback wrong");
    a_search_readback: assert property (
        clk_en_i && rd_i && addr_i == e1ssm_pkg::SYNC_STAT_ADDR
        |=> rdata_o[2:0] == $past({align_search_active_i, signaling_search_active_i,
            crc_search_active_i}))
        else $error("search flags readback wrong");
    a_count_step: assert property (
        clk_en_i && timeout_w && !count_clr_w |=> count_q == $past(count_q) + 6'h01)
        else $error("counter did not step");
    a_sync_clears: assert property (clk_en_i && crc_sync_achieved_i |=> count_q == 6'h00)
        else $error("sync did not clear counter");
    a_mode_off_clears: assert property (clk_en_i && mode_off_w |=> count_q == 6'h00)
        else $error("mode off did not clear counter");
    a_count_wraps: assert property (
        clk_en_i && timeout_w && !count_clr_w && count_q == 6'h3f |=> count_q == 6'h00)
        else $error("counter did not wrap");
    a_irq_level: assert property (clk_en_i && |(event_w & mask_q) && !wr_mask_w |=> irq_o)
        else $error("interrupt not raised");

    // Register port
    a_ctrl_write: assert property (clk_en_i && wr_ctrl_w |=> ctrl_q == $past(wdata_i))
        else $error("control write lost");
    a_mask_write: assert property (
        clk_en_i && wr_mask_w |=> mask_q == ($past(wdata_i) & used_w))
        else $error("mask write lost");
    a_stat_w1c: assert property (
        clk_en_i && wr_stat_w && (event_w & wdata_i) == 8'h00
        |=> (stat_q & $past(wdata_i)) == 8'h00)
        else $error("status bit not cleared");
    a_flags_sticky: assert property (
        clk_en_i && !wr_stat_w |=> (stat_q & $past(stat_q)) == $past(stat_q))
        else $error("status flag dropped");
    a_spare_zero: assert property (
        !stat_q[e1ssm_pkg::SPARE_BIT] && !mask_q[e1ssm_pkg::SPARE_BIT])
        else $error("spare bit set");
    a_stat_readback: assert property (
        clk_en_i && rd_i && (addr_i == e1ssm_pkg::RECV_INFO_ADDR
        || addr_i == e1ssm_pkg::IRQ_STAT_ADDR) |=> rdata_o == $past(stat_q))
        else $error("status readback wrong");
    a_ctrl_readback: assert property (
        clk_en_i && rd_i && addr_i == e1ssm_pkg::CTRL_ONE_ADDR |=> rdata_o == $past(ctrl_q))
        else $error("control readback wrong");
    a_mask_readback: assert property (
        clk_en_i && rd_i && addr_i == e1ssm_pkg::IRQ_MASK_ADDR |=> rdata_o == $past(mask_q))
        else $error("mask readback wrong");
    a_unmapped_zero: assert property (
        clk_en_i && rd_i && addr_i != e1ssm_pkg::RECV_INFO_ADDR
        && addr_i != e1ssm_pkg::SYNC_STAT_ADDR && addr_i != e1ssm_pkg::CTRL_ONE_ADDR
        && addr_i != e1ssm_pkg::IRQ_STAT_ADDR && addr_i != e1ssm_pkg::IRQ_MASK_ADDR
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (clk_en_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    a_irq_quiet: assert property (stat_q == 8'h00 |-> !irq_o)
        else $error("interrupt without flag");

    // Clock enable freeze and reset
    a_freeze_regs: assert property (
        !clk_en_i |=> $stable(stat_q) && $stable(ctrl_q) && $stable(mask_q))
        else $error("registers moved while frozen");
    a_freeze_count: assert property (
        !clk_en_i |=> $stable(count_q) && $stable(timer_q) && $stable(wcnt_q))
        else $error("counters moved while frozen");
    a_freeze_rdata: assert property (!clk_en_i |=> $stable(rdata_o))
        else $error("read data moved while frozen");
    a_reset_values: assert property (disable iff (1'b0)
        reset_i |=> stat_q == 8'h00 && count_q == 6'h00 && rdata_o == 8'h00 && !irq_o)
        else $error("reset state wrong");

    // Criteria and counter
    a_crc_met_quiet: assert property (
        clk_en_i && !(crc_err_w && ecnt_q == e1ssm_pkg::CRC_ERR_LIMIT - 10'h001) |=> !crc_met_q)
        else $error("crc criterion flagged early");
    a_crc_met_pulse: assert property (
        clk_en_i && crc_met_q |=> !crc_met_q)
        else $error("crc criterion held");
    a_window_restart: assert property (
        clk_en_i && win_end_w |=> wcnt_q == 10'h000 && ecnt_q == 10'h000)
        else $error("crc window did not restart");
    a_window_bound: assert property (
        wcnt_q < e1ssm_pkg::CRC_WINDOW && ecnt_q <= wcnt_q)
        else $error("crc window out of range");
    a_align_met_quiet: assert property (
        clk_en_i && !(align_word_i && align_word_err_i) |=> !align_if.met)
        else $error("alignment criterion without error");
    a_align_met_pulse: assert property (
        clk_en_i && align_if.met |=> !align_if.met)
        else $error("alignment criterion held");
    a_sig_met_quiet: assert property (
        clk_en_i && !(sig_word_i && sig_word_err_i) |=> !sig_if.met)
        else $error("signaling criterion without error");
    a_sig_met_pulse: assert property (
        clk_en_i && sig_if.met |=> !sig_if.met)
        else $error("signaling criterion held");
    a_timer_idle: assert property (clk_en_i && !searching_w |=> timer_q == '0)
        else $error("search timer not idle");
    a_timer_step: assert property (
        clk_en_i && searching_w && !timeout_w |=> timer_q == $past(timer_q) + 1'b1)
        else $error("search timer did not step");
    a_timer_bound: assert property (
        timer_q <= e1ssm_pkg::TIMER_W'(SEARCH_CYCLES - 1))
        else $error("search timer past period");
    a_count_holds: assert property (
        clk_en_i && !timeout_w && !count_clr_w |=> count_q == $past(count_q))
        else $error("counter moved without timeout");
    a_mode_off_zero: assert property (!crc_en_w |-> count_q == 6'h00)
        else $error("counter not held in mode off");

    c_crc_timeout: cover property (clk_en_i && timeout_w);
    c_count_wrap: cover property (clk_en_i && timeout_w && count_q == 6'h3f);
    c_crc_criterion: cover property (crc_met_q);
    c_align_criterion: cover property (align_if.met);
    c_irq_raised: cover property (!irq_o ##1 irq_o);
endmodule

// File: test/e1ssm_line_model.sv
/*
 Receive line model: sends CRC4, alignment or signaling words with error marks.
 Assumes the bench commands it on the rising edge of clk_i.
*/
`timescale 1ns/1ps
module e1ssm_line_model (
    input wire logic clk_i,
    input wire logic [1:0] sel_i,
    input wire logic send_i,
    input wire logic err_i,
    output logic crc_word_o,
    output logic crc_err_o,
    output logic align_word_o,
    output logic align_err_o,
    output logic sig_word_o,
    output logic sig_err_o
);
    // Error marks follow the command even between words
    always_ff @(posedge clk_i) begin
        crc_word_o <= send_i && sel_i == 2'h0;
        align_word_o <= send_i && sel_i == 2'h1;
        sig_word_o <= send_i && sel_i == 2'h2;
        crc_err_o <= err_i;
        align_err_o <= err_i;
        sig_err_o <= err_i;
    end
endmodule

// File: test/tb.sv
/*
 Self-checking bench of the status monitor with a receive line model.
 Assumes a 20 MHz clock and a short search period.
*/
`timescale 1ns/1ps
module tb;
    localparam int SC = 20;
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic send = 1'b0, err = 1'b0, sync = 1'b0, en = 1'b1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
    logic [3:0] ev = 4'h0;
    logic [2:0] srch = 3'h0;
    logic [1:0] sel = 2'h0;
    logic irq_o, crc_mode_en_o, cw, ce, aw, ae, sw, se;
    int miscompares = 0, samples_checked = 0;
    initial forever #25 clk_i = ~clk_i;
    e1ssm_status_monitor #(.SEARCH_CYCLES(SC)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .clk_en_i(en), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .tx_store_full_i(ev[3]), .tx_store_empty_i(ev[2]),
        .rx_store_full_i(ev[1]), .rx_store_empty_i(ev[0]), .crc_word_i(cw),
        .crc_word_err_i(ce), .align_word_i(aw), .align_word_err_i(ae), .sig_word_i(sw),
        .sig_word_err_i(se), .align_search_active_i(srch[2]),
        .signaling_search_active_i(srch[1]), .crc_search_active_i(srch[0]),
        .crc_sync_achieved_i(sync), .crc_mode_en_o(crc_mode_en_o));
    e1ssm_line_model i_line (.clk_i(clk_i), .sel_i(sel), .send_i(send), .err_i(err),
        .crc_word_o(cw), .crc_err_o(ce), .align_word_o(aw), .align_err_o(ae),
        .sig_word_o(sw), .sig_err_o(se));
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic words(input logic [1:0] k, input int n, input logic e);
        repeat (n) begin
            @(posedge clk_i);
            sel <= k;
            send <= 1'b1;
            err <= e;
        end
        @(posedge clk_i);
        send <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_reset;
        logic [7:0] a[6] = '{8'h08, 8'h1e, 8'h10, 8'h11, 8'h12, 8'h3f};
        foreach (a[i]) begin
            rd(a[i]);
            chk(d, 8'h00);
        end
        chk({7'h00, irq_o}, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_store;
        logic [7:0] b[4] = '{8'h08, 8'h10, 8'h40, 8'h80};
        for (int i = 0; i < 4; i++) begin
            wr(8'h12, i[0] ? 8'hff : 8'h00);
            @(posedge clk_i);
            ev <= 4'h1 << i;
            @(posedge clk_i);
            ev <= 4'h0;
            rd(8'h08);
            chk(d, b[i]);
            chk({7'h00, irq_o}, {7'h00, i[0]});
            wr(8'h11, b[i]);
            rd(8'h11);
            chk(d, 8'h00);
        end
        $display("store event test done");
    endtask
    task automatic t_align;
        words(2'h1, 2, 1'b1);
        words(2'h1, 1, 1'b0);
        words(2'h1, 2, 1'b1);
        rd(8'h08);
        chk(d, 8'h00);
        words(2'h1, 1, 1'b1);
        rd(8'h08);
        chk(d, 8'h02);
        wr(8'h11, 8'h02);
        words(2'h2, 1, 1'b1);
        rd(8'h08);
        chk(d, 8'h00);
        words(2'h2, 1, 1'b1);
        rd(8'h08);
        chk(d, 8'h01);
        wr(8'h11, 8'h01);
        $display("alignment test done");
    endtask
    task automatic t_crc;
        words(2'h0, 85, 1'b0);
        words(2'h0, 914, 1'b1);
        rd(8'h08);
        chk(d, 8'h00);
        words(2'h0, 1, 1'b1);
        rd(8'h08);
        chk(d, 8'h04);
        wr(8'h11, 8'h04);
        $display("crc criterion test done");
    endtask
    task automatic t_count;
        wr(8'h10, 8'h01);
        rd(8'h10);
        chk({7'h00, crc_mode_en_o}, 8'h01);
        chk(d, 8'h01);
        @(posedge clk_i);
        srch <= 3'h7;
        repeat (3 * SC + SC / 2) @(posedge clk_i);
        rd(8'h1e);
        chk(d, 8'h0f);
        repeat (61 * SC) @(posedge clk_i);
        rd(8'h1e);
        chk(d, 8'h07);
        repeat (5 * SC) @(posedge clk_i);
        rd(8'h1e);
        chk(d, 8'h1f);
        @(posedge clk_i);
        sync <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(8'h1e);
        chk(d, 8'h07);
        @(posedge clk_i);
        sync <= 1'b0;
        repeat (3 * SC) @(posedge clk_i);
        wr(8'h10, 8'h00);
        srch <= 3'h5;
        rd(8'h1e);
        chk(d, 8'h05);
        $display("counter test done");
    endtask
    task automatic t_freeze;
        @(posedge clk_i);
        en <= 1'b0;
        ev <= 4'h8;
        wr(8'h10, 8'h01);
        ev <= 4'h0;
        en <= 1'b1;
        rd(8'h08);
        chk(d, 8'h00);
        rd(8'h10);
        chk(d, 8'h00);
        chk({7'h00, crc_mode_en_o}, 8'h00);
        rd(8'h1e);
        chk(d, 8'h05);
        @(posedge clk_i);
        #1 chk(rdata_o, 8'h00);
        $display("clock enable test done");
    endtask
    initial begin
        #1000000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_store();
        t_align();
        t_crc();
        t_count();
        t_freeze();
        final_report();
    end
endmodule
